// ===== rtl/ris_slave.sv
// Two-wire bus slave of the real-time clock with write buffer
// Contract
// - Both lines released and high whenever no transfer is running.
// - Data falling while clock high is a start; device detects it.
// - Data rising while clock high is a stop; transaction ends.
// - Start before any stop is a repeated start, handled like start.
// - Stop accepted at any point while receiving; abort cleanly.
// - Transaction of 0.95 s or more clears interface; writes dropped.
// - Reads during or after timeout clear return all ones.
// - After timeout clear, only a new start resumes communication.
// - Data moves in 8-bit bytes, any number per transaction.
// - Register address advances by one after every byte transferred.
// - Auto-increment wraps 0Fh to 00h within the block.
// - Transmitter changes data while clock low; receiver samples high.
// - Data change with clock high is never taken as a data bit.
// - Receiver acknowledges each byte low; missing ack means failure. A data byte that finds the write buffer full gets no ack here.
// - After 8th falling edge transmitter releases, receiver pulls low.
// - Acknowledger releases data at falling edge of 9th bit.
// - Missing master ack ends read; device releases, waits for stop.
// - Respond and acknowledge only when received address matches.
// - Address 0110010 plus direction bit: 65h read, 64h write.
// - Both lines driven open-drain only, forming a wired AND.
// - First written byte sets register address, rest are data.
// - Read without address starts at previous address plus one.
// - Time values frozen from start, update applied after end.
`timescale 1ns/10ps
`include "ris_regs.svh"

module ris_fifo
  import ris_pkg::*;
#(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic full;
  logic empty;

  assign empty = wr_ptr_q == rd_ptr_q;
  assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
    (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr_q[AW-1:0]];

  always_ff @(posedge core_clk)
  begin
    if (in_valid && !full)
    begin
      mem[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      wr_ptr_q <= '0;
    end
    else if (in_valid && !full)
    begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      rd_ptr_q <= '0;
    end
    else if (out_ready && !empty)
    begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end
endmodule // ris_fifo

module ris_slave
  import ris_pkg::*;
#(
  parameter int TIMEOUT_CYC = `RIS_TIMEOUT_CYC
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic [4:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output ris_wr_s wr_item,
  output logic hold_time
);
  ris_lines_s meta_q;
  ris_lines_s sync_q;
  ris_lines_s prev_q;
  ris_state_e state_q;
  logic [3:0] cnt_q;
  logic [7:0] rx_sh_q;
  logic [7:0] tx_sh_q;
  logic [4:0] ptr_q;
  logic first_q;
  logic sda_oe_q;
  logic sda_o_q;
  logic scl_oe_q;
  logic scl_o_q;
  logic busy_q;
  logic to_q;
  logic [31:0] to_cnt_q;
  logic out_valid_q;
  ris_wr_s out_q;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic timeout_ev;
  logic byte_done;
  logic push;
  logic ptr_inc;
  logic f_in_ready;
  logic f_out_valid;
  logic f_pop;
  ris_wr_s f_out;
  ris_wr_s push_item;

  // Next register address; each 16-entry block wraps on itself
  function automatic logic [4:0] ptr_next(input logic [4:0] p);
    ptr_next = {p[4], p[3:0] + 4'h1};
  endfunction

  // Two-stage synchroniser, then a third stage for edge finding
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end
    else
    begin
      meta_q <= '{scl: scl_i, sda: sda_i};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign scl_rise = sync_q.scl && !prev_q.scl;
  assign scl_fall = !sync_q.scl && prev_q.scl;
  // Data edges with clock steady high are conditions, never bits
  assign start_ev = sync_q.scl && prev_q.scl &&
    prev_q.sda && !sync_q.sda;
  assign stop_ev = sync_q.scl && prev_q.scl &&
    !prev_q.sda && sync_q.sda;
  assign timeout_ev = busy_q && (to_cnt_q >= TIMEOUT_CYC - 1);
  assign byte_done = scl_fall && (cnt_q == `RIS_BYTE_BITS);
  assign push_item = '{addr: ptr_q, data: rx_sh_q};
  // Full buffer refuses the byte with a missing acknowledge
  assign push = (state_q == RIS_RX) && byte_done && !first_q &&
    f_in_ready && !to_q;
  assign ptr_inc = push || ((state_q == RIS_TX) && byte_done);
  assign f_pop = f_out_valid && (!out_valid_q || wr_ready);

  ris_fifo #(
    .WIDTH($bits(ris_wr_s)),
    .DEPTH(`RIS_FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data(push_item),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out)
  );

  // Output stage keeps the write port on flip-flops
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      out_valid_q <= 1'b0;
      out_q <= '0;
    end
    else if (f_pop)
    begin
      out_valid_q <= 1'b1;
      out_q <= f_out;
    end
    else if (wr_ready)
    begin
      out_valid_q <= 1'b0;
    end
  end

  // Transaction span: start to stop, repeated starts included
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      busy_q <= 1'b0;
      to_cnt_q <= '0;
      to_q <= 1'b0;
    end
    else if (start_ev)
    begin
      busy_q <= 1'b1;
      to_q <= 1'b0;
      if (!busy_q)
      begin
        to_cnt_q <= '0;
      end
    end
    else if (stop_ev)
    begin
      busy_q <= 1'b0;
      to_cnt_q <= '0;
    end
    else if (timeout_ev)
    begin
      busy_q <= 1'b0;
      to_q <= 1'b1;
      to_cnt_q <= '0;
    end
    else if (busy_q)
    begin
      to_cnt_q <= to_cnt_q + 32'h1;
    end
  end

  // Clock line is never pulled; no stretching
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      scl_oe_q <= 1'b0;
      scl_o_q <= 1'b0;
      sda_o_q <= 1'b0;
    end
    else
    begin
      scl_oe_q <= 1'b0;
      scl_o_q <= 1'b0;
      sda_o_q <= 1'b0;
    end
  end

  // Register address pointer survives between transactions
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      ptr_q <= `RIS_PTR_RST;
    end
    else if ((state_q == RIS_RX) && byte_done && first_q)
    begin
      ptr_q <= rx_sh_q[4:0];
    end
    else if (ptr_inc)
    begin
      ptr_q <= ptr_next(ptr_q);
    end
  end

  // Receive shifter and bit counter, sampled while clock high
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      rx_sh_q <= '0;
      cnt_q <= '0;
    end
    else if (start_ev || scl_fall && cnt_q == `RIS_BYTE_BITS)
    begin
      cnt_q <= '0;
    end
    // The ninth clock carries the acknowledge; counting it would end
    // every following byte one bit early
    else if (scl_rise && cnt_q != `RIS_BYTE_BITS &&
      state_q != RIS_ADDR_ACK && state_q != RIS_RX_ACK &&
      state_q != RIS_TX_ACK)
    begin
      rx_sh_q <= {rx_sh_q[6:0], sync_q.sda};
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // Protocol sequencer and data line drive
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_q <= RIS_IDLE;
      sda_oe_q <= 1'b0;
      tx_sh_q <= `RIS_ALL_ONES;
      first_q <= 1'b0;
    end
    else if (start_ev)
    begin
      state_q <= RIS_ADDR;
      sda_oe_q <= 1'b0;
    end
    else if (stop_ev || timeout_ev)
    begin
      // Released line reads as ones until the next start
      state_q <= RIS_IDLE;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        RIS_IDLE, RIS_IGNORE:
        begin
          sda_oe_q <= 1'b0;
        end
        RIS_ADDR:
        begin
          if (byte_done)
          begin
            if (rx_sh_q[7:1] == `RIS_SLAVE_ADDR)
            begin
              state_q <= RIS_ADDR_ACK;
              sda_oe_q <= 1'b1;
              first_q <= (rx_sh_q[0] == `RIS_DIR_WRITE);
            end
            else
            begin
              state_q <= RIS_IGNORE;
            end
          end
        end
        RIS_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            if (!first_q)
            begin
              // Pointer already holds the written address or previous access plus one
              state_q <= RIS_TX;
              tx_sh_q <= to_q ? `RIS_ALL_ONES : rd_data;
              sda_oe_q <= to_q ? 1'b0 : !rd_data[7];
            end
            else
            begin
              state_q <= RIS_RX;
              sda_oe_q <= 1'b0;
            end
          end
        end
        RIS_RX:
        begin
          if (byte_done)
          begin
            state_q <= RIS_RX_ACK;
            sda_oe_q <= first_q || push;
          end
        end
        RIS_RX_ACK:
        begin
          if (scl_fall)
          begin
            state_q <= RIS_RX;
            sda_oe_q <= 1'b0;
            first_q <= 1'b0;
          end
        end
        RIS_TX:
        begin
          if (byte_done)
          begin
            state_q <= RIS_TX_ACK;
            sda_oe_q <= 1'b0;
          end
          else if (scl_fall)
          begin
            tx_sh_q <= {tx_sh_q[6:0], 1'b1};
            sda_oe_q <= !tx_sh_q[6];
          end
        end
        RIS_TX_ACK:
        begin
          if (scl_rise && sync_q.sda)
          begin
            state_q <= RIS_IGNORE;
          end
          else if (scl_fall)
          begin
            state_q <= RIS_TX;
            tx_sh_q <= rd_data;
            sda_oe_q <= !rd_data[7];
          end
        end
      endcase
    end
  end

  assign scl_o = scl_o_q;
  assign scl_oe = scl_oe_q;
  assign sda_o = sda_o_q;
  assign sda_oe = sda_oe_q;
  assign rd_addr = ptr_q;
  assign wr_valid = out_valid_q;
  assign wr_item = out_q;
  assign hold_time = busy_q;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  idle_released_a: assert property (
    state_q == RIS_IDLE |-> !sda_oe_q)
    else $error("data line driven while idle");
  start_to_addr_a: assert property (
    start_ev |=> state_q == RIS_ADDR && !sda_oe_q)
    else $error("start not taken");
  stop_releases_a: assert property (
    stop_ev |=> state_q == RIS_IDLE && !sda_oe_q && !hold_time)
    else $error("stop not honoured");
  addr_mismatch_a: assert property (
    state_q == RIS_ADDR && byte_done && !start_ev && !stop_ev &&
    !timeout_ev && rx_sh_q[7:1] != `RIS_SLAVE_ADDR
    |=> state_q == RIS_IGNORE ##1 !sda_oe_q)
    else $error("foreign address acknowledged");
  addr_wrap_a: assert property (
    ptr_inc && ptr_q[3:0] == 4'hf |=> ptr_q[3:0] == 4'h0 &&
    ptr_q[4] == $past(ptr_q[4]))
    else $error("address did not wrap");
  timeout_clear_a: assert property (
    timeout_ev && !start_ev && !stop_ev
    |=> state_q == RIS_IDLE && !hold_time && !sda_oe_q)
    else $error("timeout did not clear");
  drive_on_low_a: assert property (
    $rose(sda_oe_q) |-> $past(scl_fall))
    else $error("data driven outside clock low");
  clock_never_a: assert property (
    !scl_oe && !sda_o)
    else $error("line driven high or clock pulled");
  push_ready_a: assert property (
    push |-> f_in_ready ##1 state_q == RIS_RX_ACK && sda_oe_q)
    else $error("write without acknowledge");
  nack_ends_a: assert property (
    state_q == RIS_TX_ACK && scl_rise && sync_q.sda && !stop_ev &&
    !start_ev && !timeout_ev |=> state_q == RIS_IGNORE [*2])
    else $error("read continued after nack");

  write_seen_c: cover property (push ##[1:40] wr_valid);
  read_byte_c: cover property (state_q == RIS_TX ##1 state_q == RIS_TX_ACK);
  timeout_c: cover property (timeout_ev);
  restart_c: cover property (busy_q && start_ev);
endmodule // ris_slave

// ===== pkg/ris_regs.svh
// Constants of the real-time-clock two-wire slave interface
`ifndef RIS_REGS_SVH
`define RIS_REGS_SVH
// Fixed 7-bit bus address and direction bit encodings
`define RIS_SLAVE_ADDR 7'h32
`define RIS_DIR_READ 1'b1
`define RIS_DIR_WRITE 1'b0
// Register address width and reset value of the pointer
`define RIS_PTR_W 5
`define RIS_PTR_RST 5'h00
// Bits in one byte and value read back after a timeout clear
`define RIS_BYTE_BITS 4'h8
`define RIS_ALL_ONES 8'hff
// Transaction time limit and core clock rate
`define RIS_TIMEOUT_MS 950
`define RIS_CLK_KHZ 50000
`define RIS_TIMEOUT_CYC (`RIS_TIMEOUT_MS * `RIS_CLK_KHZ)
// Least bus-free time between stop and start, kept by the master
`define RIS_BUS_FREE_NS 1300
// Write stream buffer depth
`define RIS_FIFO_DEPTH 8
`endif

// ===== pkg/ris_pkg.sv
// Types of the real-time-clock two-wire slave interface
package ris_pkg;
  typedef enum logic [2:0] {
    RIS_IDLE = 3'b000,
    RIS_ADDR = 3'b001,
    RIS_ADDR_ACK = 3'b010,
    RIS_RX = 3'b011,
    RIS_RX_ACK = 3'b100,
    RIS_TX = 3'b101,
    RIS_TX_ACK = 3'b110,
    RIS_IGNORE = 3'b111
  } ris_state_e;

  // One register write leaving the bus side
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
  } ris_wr_s;

  // Synchronised bus line levels
  typedef struct packed {
    logic scl;
    logic sda;
  } ris_lines_s;
endpackage

// ===== test/ris_master.sv
// Two-wire bus master model that drives both lines open drain
`timescale 1ns/10ps
module ris_master
(
  output logic scl_m,
  output logic sda_m,
  input wire logic sda_w
);
  // Released at time zero; the clock stands still between frames
  initial
  begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end

  // Only this model makes start, repeated start and stop
  task automatic send_start();
    #80 sda_m = 1'b1;
    #80 scl_m = 1'b1;
    #80 sda_m = 1'b0;
    #80 scl_m = 1'b0;
  endtask

  task automatic send_stop();
    #80 sda_m = 1'b0;
    #80 scl_m = 1'b1;
    #80 sda_m = 1'b1;
    #1300;
  endtask

  // Long low phase leaves room for the slave's late release
  task automatic clk_bit(input logic b, output logic s);
    #20 sda_m = b;
    #80 scl_m = 1'b1;
    #30 s = sda_w;
    #30 scl_m = 1'b0;
  endtask

  task automatic byte_wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], s);
    clk_bit(1'b1, ack);
  endtask

  task automatic byte_rd(output logic [7:0] d, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b1, d[i]);
    clk_bit(nack, s);
  endtask
endmodule // ris_master

// ===== test/tb_top.sv
// Self-checking bench of the two-wire slave with its write buffer
`timescale 1ns/10ps
`include "ris_regs.svh"
module tb_top
  import ris_pkg::*;
();
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wr_ready = 1'b0;
  logic rdy_en = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic scl_m, sda_m, scl_o, scl_oe, sda_o, sda_oe, wr_valid, hold_time;
  logic [4:0] rd_addr;
  ris_wr_s wr_item;
  logic [7:0] mem [32];
  ris_wr_s got_q [$];
  ris_wr_s exp_q [$];
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  wire scl_w = scl_m & ~(scl_oe & ~scl_o);
  wire sda_w = sda_m & ~(sda_oe & ~sda_o);

  always #10 core_clk = ~core_clk;

  ris_slave #(.TIMEOUT_CYC(2000)) u_dut (
    .core_clk(core_clk), .reset_n(reset_n),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .rd_addr(rd_addr), .rd_data(rd_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_item(wr_item),
    .hold_time(hold_time)
  );

  ris_master u_m (.scl_m(scl_m), .sda_m(sda_m), .sda_w(sda_w));

  // Register file stand-in and a write consumer that stalls at random
  always @(posedge core_clk)
  begin
    rd_data <= mem[rd_addr];
    wr_ready <= rdy_en & 1'($urandom);
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      got_q.push_back(wr_item);
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_errors++;
      close_out();
    end
  end

  function automatic logic [4:0] nxt(input logic [4:0] p);
    return {p[4], p[3:0] + 4'h1};
  endfunction

  task automatic note(input bit bad, input logic [12:0] g, e);
    check_count++;
    if (bad)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_bit(input logic g, input logic e);
    note(g !== e, 13'(g), 13'(e));
  endtask

  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    note(g !== e, 13'(g), 13'(e));
  endtask

  task automatic cmp_wr(input ris_wr_s g, input ris_wr_s e);
    note(g !== e, g, e);
  endtask

  task automatic wb(input logic [7:0] d, input logic e);
    logic a;
    u_m.byte_wr(d, a);
    cmp_bit(a, e);
  endtask

  task automatic rb(input logic [7:0] e, input logic nack);
    logic [7:0] d;
    u_m.byte_rd(d, nack);
    cmp_byte(d, e);
  endtask

  task automatic drain();
    repeat (80) @(posedge core_clk);
    cmp_byte(8'(got_q.size()), 8'(exp_q.size()));
    for (int i = 0; i < got_q.size() && i < exp_q.size(); i++)
      cmp_wr(got_q[i], exp_q[i]);
    got_q.delete();
    exp_q.delete();
  endtask

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    logic [4:0] p;
    logic [7:0] d;
    logic a;
    int acks;
    void'($urandom(32'hee35));
    foreach (mem[i])
      mem[i] = 8'($urandom);
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    rdy_en <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    cmp_bit(sda_oe, 1'b0);
    cmp_bit(scl_oe, 1'b0);
    cmp_bit(hold_time, 1'b0);
    cmp_bit(sda_o, 1'b0);
    cmp_bit(scl_o, 1'b0);
    // Write that crosses the wrap of the low block
    u_m.send_start();
    wb(8'h64, 1'b0);
    cmp_bit(hold_time, 1'b1);
    p = 5'h0e;
    wb({3'h0, p}, 1'b0);
    repeat (3)
    begin
      d = 8'($urandom);
      wb(d, 1'b0);
      exp_q.push_back(ris_wr_s'{p, d});
      p = nxt(p);
    end
    u_m.send_stop();
    cmp_bit(hold_time, 1'b0);
    drain();
    cmp_byte({3'h0, rd_addr}, {3'h0, p});
    // Pointed reads through a repeated start, both blocks wrap
    for (int j = 0; j < 2; j++)
    begin
      p = j ? 5'h1f : 5'h0f;
      u_m.send_start();
      wb(8'h64, 1'b0);
      wb({3'h0, p}, 1'b0);
      u_m.send_start();
      wb(8'h65, 1'b0);
      for (int k = 0; k < 3; k++)
      begin
        rb(mem[p], k == 2);
        p = nxt(p);
      end
      #200;
      cmp_bit(sda_oe, 1'b0);
      u_m.send_stop();
    end
    // Read with no pointer continues after the last access
    u_m.send_start();
    wb(8'h65, 1'b0);
    rb(mem[p], 1'b1);
    u_m.send_stop();
    // Foreign addresses are ignored, writes included
    repeat (4)
    begin
      d = {`RIS_SLAVE_ADDR ^ 7'($urandom_range(1, 127)), 1'($urandom)};
      u_m.send_start();
      wb(d, 1'b1);
      wb(8'h00, 1'b1);
      u_m.send_stop();
    end
    // Stop in mid byte, then a clean write
    u_m.send_start();
    wb(8'h64, 1'b0);
    wb(8'h03, 1'b0);
    repeat (4) u_m.clk_bit(1'b0, a);
    u_m.send_stop();
    u_m.send_start();
    wb(8'h64, 1'b0);
    wb(8'h04, 1'b0);
    d = 8'($urandom);
    wb(d, 1'b0);
    exp_q.push_back(ris_wr_s'{5'h04, d});
    u_m.send_stop();
    drain();
    // Stalled consumer: buffer fills and the slave refuses
    rdy_en <= 1'b0;
    acks = 0;
    p = 5'h10;
    u_m.send_start();
    wb(8'h64, 1'b0);
    wb({3'h0, p}, 1'b0);
    repeat (10)
    begin
      d = 8'($urandom);
      u_m.byte_wr(d, a);
      if (a === 1'b0)
      begin
        acks++;
        exp_q.push_back(ris_wr_s'{p, d});
        p = nxt(p);
      end
    end
    u_m.send_stop();
    cmp_byte(8'(acks), 8'h09);
    rdy_en <= 1'b1;
    drain();
    // Over-long transaction is cleared; only a new start revives it
    u_m.send_start();
    wb(8'h64, 1'b0);
    wb(8'h07, 1'b0);
    repeat (2100) @(posedge core_clk);
    #1;
    cmp_bit(hold_time, 1'b0);
    wb(8'h5a, 1'b1);
    rb(8'hff, 1'b0);
    u_m.send_stop();
    u_m.send_start();
    wb(8'h64, 1'b0);
    u_m.send_stop();
    drain();
    close_out();
  end
endmodule // tb_top
